/* core/csb_pkg.sv */
// constants and types for the compare, skip and branch execution block
package csb_pkg;

  // ==========================================================================
  // widths
  localparam int DATA_WIDTH   = 8;
  localparam int PC_WIDTH     = 16;
  localparam int OFFSET_WIDTH = 7;
  localparam int BITSEL_WIDTH = 3;

  // ==========================================================================
  // status flag bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // flags written by every compare
  localparam logic [7:0] CMP_FLAG_MASK = 8'h3F;

  // ==========================================================================
  // program counter steps in words
  localparam int PC_STEP_SEQ    = 1;
  localparam int PC_SKIP_SHORT  = 2;
  localparam int PC_SKIP_LONG   = 3;
  localparam int PC_BRANCH_BIAS = 1;

  // ==========================================================================
  // reset values
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic       FLAG_RESET   = 1'b0;

  // ==========================================================================
  // operation codes
  typedef enum logic [3:0] {
    no_op                 = 4'h0,
    compare_op            = 4'h1,
    compare_with_carry_op = 4'h2,
    compare_immediate_op  = 4'h3,
    skip_reg_bit_clear_op = 4'h4,
    skip_reg_bit_set_op   = 4'h5,
    skip_io_bit_clear_op  = 4'h6,
    skip_io_bit_set_op    = 4'h7,
    branch_flag_set_op    = 4'h8,
    branch_flag_clear_op  = 4'h9,
    branch_equal_op       = 4'hA
  } csb_op_e;

endpackage : csb_pkg

/* core/csb_alu_if.sv */
// carrier between the execution core and its subtract-and-flags unit
`timescale 1ns/10ps
interface csb_alu_if;
  import csb_pkg::*;

  logic [DATA_WIDTH-1:0] minuend;
  logic [DATA_WIDTH-1:0] subtrahend;
  logic                  carry_in;
  logic                  use_carry;
  logic                  zero_in;
  logic [DATA_WIDTH-1:0] difference;
  logic [7:0]            flags;

  modport alu (
    input  minuend,
    input  subtrahend,
    input  carry_in,
    input  use_carry,
    input  zero_in,
    output difference,
    output flags
  );

  modport core (
    output minuend,
    output subtrahend,
    output carry_in,
    output use_carry,
    output zero_in,
    input  difference,
    input  flags
  );

endinterface : csb_alu_if

/* core/csb_sub_flags.sv */
// subtract without store, producing the compare flags
`timescale 1ns/10ps
module csb_sub_flags
  import csb_pkg::*;
(
  csb_alu_if.alu bus
);

  // ==========================================================================
  // subtraction
  wire logic [DATA_WIDTH-1:0] borrow_in;
  wire logic [DATA_WIDTH-1:0] res;
  wire logic                  d7;
  wire logic                  s7;
  wire logic                  r7;
  wire logic                  d3;
  wire logic                  s3;
  wire logic                  r3;
  wire logic                  res_zero;

  assign borrow_in = {{(DATA_WIDTH-1){1'b0}}, bus.use_carry & bus.carry_in};
  assign res       = bus.minuend - bus.subtrahend - borrow_in;
  assign d7        = bus.minuend[DATA_WIDTH-1];
  assign s7        = bus.subtrahend[DATA_WIDTH-1];
  assign r7        = res[DATA_WIDTH-1];
  assign d3        = bus.minuend[3];
  assign s3        = bus.subtrahend[3];
  assign r3        = res[3];
  // carry variant keeps zero only if it was already set
  assign res_zero  = (res == '0) & (~bus.use_carry | bus.zero_in);

  // ==========================================================================
  // flags, placed at their status positions
  wire logic flag_c;
  wire logic flag_z;
  wire logic flag_n;
  wire logic flag_v;
  wire logic flag_h;

  assign flag_c = (~d7 & s7) | (s7 & r7) | (r7 & ~d7);
  assign flag_h = (~d3 & s3) | (s3 & r3) | (r3 & ~d3);
  assign flag_v = (d7 & ~s7 & ~r7) | (~d7 & s7 & r7);
  assign flag_n = r7;
  assign flag_z = res_zero;

  assign bus.difference = res;
  assign bus.flags = (8'h01 << FLAG_C) & {8{flag_c}}
                   | (8'h01 << FLAG_Z) & {8{flag_z}}
                   | (8'h01 << FLAG_N) & {8{flag_n}}
                   | (8'h01 << FLAG_V) & {8{flag_v}}
                   | (8'h01 << FLAG_S) & {8{flag_n ^ flag_v}}
                   | (8'h01 << FLAG_H) & {8{flag_h}};

endmodule : csb_sub_flags

/* core/csb_exec.sv */
// execution of the compare, skip and branch instruction group
//
// Functional notes
// - register compares subtract source (and carry for the carry form) from destination, store nothing, touch only flags.
// - the immediate compare subtracts the encoded constant from the destination and only updates flags.
// - all compares update negative, overflow, carry and half carry from the difference; zero too, but the carry form only keeps a zero already set.
// - a register bit skip tests the chosen bit and, on a match, moves the pc on by 2 or 3 words.
// - an io bit skip tests the addressed io bit and, on a match, moves the pc on by 2 or 3 words.
// - a flag branch tests the chosen status bit and, on a match, loads pc plus signed offset plus 1.
// - branch if equal jumps to pc plus offset plus 1 only when zero is set.
// - skips and branches leave every status flag as it was, taken or not.
`timescale 1ns/10ps
module csb_exec
  import csb_pkg::*;
#(
  parameter int PC_W  = PC_WIDTH,
  parameter int OFS_W = OFFSET_WIDTH
)
(
  input  wire logic                    ref_clk,
  input  wire logic                    rst_n,
  input  wire logic                    op_valid,
  input  wire csb_op_e                 op_code,
  input  wire logic [DATA_WIDTH-1:0]   dest_value,
  input  wire logic [DATA_WIDTH-1:0]   source_register,
  input  wire logic [DATA_WIDTH-1:0]   imm_value,
  input  wire logic [BITSEL_WIDTH-1:0] bit_sel,
  input  wire logic                    io_bit_value,
  input  wire logic [7:0]              status_flags_register,
  input  wire logic [PC_W-1:0]         pc_in,
  input  wire logic [OFS_W-1:0]        branch_offset,
  input  wire logic                    next_is_two_word,
  output logic [7:0]                   status_out,
  output logic                         status_we,
  output logic [PC_W-1:0]              pc_out,
  output logic                         pc_we,
  output logic                         skip_taken,
  output logic                         branch_taken,
  output logic                         op_illegal
);

  // ==========================================================================
  // output registers
  // one-cycle pulses and the held pc, all cleared by reset
  logic [7:0]      status_out_reg;
  logic [7:0]      status_out_next;
  logic            status_we_reg;
  logic            status_we_next;
  logic [PC_W-1:0] pc_out_reg;
  logic [PC_W-1:0] pc_out_next;
  logic            pc_we_reg;
  logic            pc_we_next;
  logic            skip_taken_reg;
  logic            skip_taken_next;
  logic            branch_taken_reg;
  logic            branch_taken_next;
  logic            op_illegal_reg;
  logic            op_illegal_next;

  // ==========================================================================
  // decode
  // codes above the last defined operation are illegal
  wire logic is_cmp_reg;
  wire logic is_cmp_carry;
  wire logic is_cmp_imm;
  wire logic is_compare;
  wire logic is_skip_rc;
  wire logic is_skip_rs;
  wire logic is_skip_ic;
  wire logic is_skip_is;
  wire logic is_skip;
  wire logic is_br_set;
  wire logic is_br_clr;
  wire logic is_br_eq;
  wire logic is_branch;
  wire logic is_nop;
  wire logic is_known;

  assign is_cmp_reg   = (op_code == compare_op);
  assign is_cmp_carry = (op_code == compare_with_carry_op);
  assign is_cmp_imm   = (op_code == compare_immediate_op);
  assign is_compare   = is_cmp_reg | is_cmp_carry | is_cmp_imm;
  assign is_skip_rc   = (op_code == skip_reg_bit_clear_op);
  assign is_skip_rs   = (op_code == skip_reg_bit_set_op);
  assign is_skip_ic   = (op_code == skip_io_bit_clear_op);
  assign is_skip_is   = (op_code == skip_io_bit_set_op);
  assign is_skip      = is_skip_rc | is_skip_rs | is_skip_ic | is_skip_is;
  assign is_br_set    = (op_code == branch_flag_set_op);
  assign is_br_clr    = (op_code == branch_flag_clear_op);
  assign is_br_eq     = (op_code == branch_equal_op);
  assign is_branch    = is_br_set | is_br_clr | is_br_eq;
  assign is_nop       = (op_code == no_op);
  assign is_known     = is_compare | is_skip | is_branch | is_nop;

  // ==========================================================================
  // status forwarding: a compare one cycle earlier is not yet in the
  // caller's register, so its result is used in its place
  // a carry compare right behind a compare chains the forwarded flags, not stale ones
  wire logic [7:0] eff_status;

  assign eff_status = status_we_reg ? status_out_reg : status_flags_register;

  // ==========================================================================
  // compare datapath
  // the immediate form differs from the register form only in its subtrahend
  csb_alu_if alu_bus ();

  assign alu_bus.minuend    = dest_value;
  assign alu_bus.subtrahend = is_cmp_imm ? imm_value : source_register;
  assign alu_bus.carry_in   = eff_status[FLAG_C];
  assign alu_bus.use_carry  = is_cmp_carry;
  assign alu_bus.zero_in    = eff_status[FLAG_Z];

  csb_sub_flags u_sub_flags (
    .bus (alu_bus)
  );

  wire logic [7:0] cmp_status;

  // only the compare flags change, the difference is dropped
  assign cmp_status = (eff_status & ~CMP_FLAG_MASK)
                    | (alu_bus.flags & CMP_FLAG_MASK);

  // ==========================================================================
  // skip and branch conditions
  // the io bit arrives already picked out, bit_sel does not reach it
  wire logic reg_bit;
  wire logic flag_bit;
  wire logic skip_hit;
  wire logic branch_hit;

  assign reg_bit  = source_register[bit_sel];
  assign flag_bit = eff_status[bit_sel];

  assign skip_hit = (is_skip_rc & ~reg_bit)
                  | (is_skip_rs &  reg_bit)
                  | (is_skip_ic & ~io_bit_value)
                  | (is_skip_is &  io_bit_value);

  assign branch_hit = (is_br_set &  flag_bit)
                    | (is_br_clr & ~flag_bit)
                    | (is_br_eq  &  eff_status[FLAG_Z]);

  // ==========================================================================
  // program counter targets
  // pc sums wrap at PC_W bits, as word addresses do
  localparam logic [PC_W-1:0] STEP_SEQ   = PC_W'(PC_STEP_SEQ);
  localparam logic [PC_W-1:0] STEP_SHORT = PC_W'(PC_SKIP_SHORT);
  localparam logic [PC_W-1:0] STEP_LONG  = PC_W'(PC_SKIP_LONG);
  localparam logic [PC_W-1:0] STEP_BIAS  = PC_W'(PC_BRANCH_BIAS);

  wire logic [PC_W-1:0] offset_ext;
  wire logic [PC_W-1:0] pc_seq;
  wire logic [PC_W-1:0] pc_skip;
  wire logic [PC_W-1:0] pc_branch;
  wire logic [PC_W-1:0] pc_target;

  assign offset_ext = {{(PC_W-OFS_W){branch_offset[OFS_W-1]}},
                       branch_offset};
  assign pc_seq     = pc_in + STEP_SEQ;
  assign pc_skip    = pc_in + (next_is_two_word ? STEP_LONG
                                                : STEP_SHORT);
  assign pc_branch  = pc_in + offset_ext + STEP_BIAS;

  assign pc_target  = skip_hit   ? pc_skip   :
                      branch_hit ? pc_branch :
                                   pc_seq;

  // ==========================================================================
  // next values
  // illegal codes raise op_illegal, hold pc_out and drive pc_we and status_we low
  wire logic accept;

  assign accept = op_valid & is_known;

  // skips and branches pass the status through with no write
  assign status_out_next   = (op_valid & is_compare) ? cmp_status
                                                     : eff_status;
  assign status_we_next    = op_valid & is_compare;
  assign pc_out_next       = accept ? pc_target : pc_out_reg;
  assign pc_we_next        = accept;
  assign skip_taken_next   = op_valid & skip_hit;
  assign branch_taken_next = op_valid & branch_hit;
  assign op_illegal_next   = op_valid & ~is_known;

  // ==========================================================================
  // registers
  // pc_out keeps its last target while pc_we is low
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_out_reg   <= STATUS_RESET;
      status_we_reg    <= FLAG_RESET;
      pc_out_reg       <= '0;
      pc_we_reg        <= FLAG_RESET;
      skip_taken_reg   <= FLAG_RESET;
      branch_taken_reg <= FLAG_RESET;
      op_illegal_reg   <= FLAG_RESET;
    end else begin
      status_out_reg   <= status_out_next;
      status_we_reg    <= status_we_next;
      pc_out_reg       <= pc_out_next;
      pc_we_reg        <= pc_we_next;
      skip_taken_reg   <= skip_taken_next;
      branch_taken_reg <= branch_taken_next;
      op_illegal_reg   <= op_illegal_next;
    end
  end

  // ==========================================================================
  // outputs
  // every output is a flop, nothing is decoded after the registers
  assign status_out   = status_out_reg;
  assign status_we    = status_we_reg;
  assign pc_out       = pc_out_reg;
  assign pc_we        = pc_we_reg;
  assign skip_taken   = skip_taken_reg;
  assign branch_taken = branch_taken_reg;
  assign op_illegal   = op_illegal_reg;

endmodule : csb_exec

/* dv/csb_exec_sva.sv */
// assertion checker for the compare, skip and branch execution block
`timescale 1ns/10ps
module csb_exec_sva
  import csb_pkg::*;
#(
  parameter int PC_W  = PC_WIDTH,
  parameter int OFS_W = OFFSET_WIDTH
)
(
  input wire logic                    ref_clk,
  input wire logic                    rst_n,
  input wire logic                    op_valid,
  input wire csb_op_e                 op_code,
  input wire logic [DATA_WIDTH-1:0]   dest_value,
  input wire logic [DATA_WIDTH-1:0]   source_register,
  input wire logic [DATA_WIDTH-1:0]   imm_value,
  input wire logic [BITSEL_WIDTH-1:0] bit_sel,
  input wire logic                    io_bit_value,
  input wire logic [PC_W-1:0]         pc_in,
  input wire logic [OFS_W-1:0]        branch_offset,
  input wire logic                    next_is_two_word,
  input wire logic [7:0]              status_out,
  input wire logic                    status_we,
  input wire logic [PC_W-1:0]         pc_out,
  input wire logic                    pc_we,
  input wire logic                    skip_taken,
  input wire logic                    branch_taken
);
  // ==========================================================================
  // helper logic
  logic            is_cmp;
  logic            is_sb;
  logic [PC_W-1:0] ofs_ext;
  logic [PC_W-1:0] tgt_reg;
  logic [PC_W-1:0] seq_reg;
  logic [7:0]      diff_reg;
  assign is_cmp  = op_valid
    && (op_code inside {[compare_op:compare_immediate_op]});
  assign is_sb   = op_valid
    && (op_code inside {[skip_reg_bit_clear_op:branch_equal_op]});
  assign ofs_ext = {{(PC_W-OFS_W){branch_offset[OFS_W-1]}}, branch_offset};
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tgt_reg  <= '0;
      seq_reg  <= '0;
      diff_reg <= 8'h00;
    end else begin
      tgt_reg  <= pc_in + ofs_ext + 1'b1;
      seq_reg  <= pc_in + 1'b1;
      diff_reg <= dest_value - source_register;
    end
  end

  // ==========================================================================
  // properties
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_cmp_we; is_cmp |=> status_we && pc_we; endproperty
  a_cmp_we: assert property (p_cmp_we)
    else $error("compare did not write status");
  property p_cmp_c; op_valid && op_code == compare_op
    |=> status_out[FLAG_C] == ($past(dest_value) < $past(source_register));
  endproperty
  a_cmp_c: assert property (p_cmp_c)
    else $error("compare carry wrong");
  property p_cmp_n; op_valid && op_code == compare_op
    |=> status_out[FLAG_N] == diff_reg[7]; endproperty
  a_cmp_n: assert property (p_cmp_n)
    else $error("compare negative wrong");
  property p_cmpi_z; op_valid && op_code == compare_immediate_op
    |=> status_out[FLAG_Z] == ($past(dest_value) == $past(imm_value));
  endproperty
  a_cmpi_z: assert property (p_cmpi_z)
    else $error("immediate compare zero wrong");
  property p_skip_reg; op_valid && op_code == skip_reg_bit_set_op
    && source_register[bit_sel] && !next_is_two_word
    |=> skip_taken && pc_out == $past(pc_in) + 2'd2; endproperty
  a_skip_reg: assert property (p_skip_reg)
    else $error("register bit skip pc wrong");
  property p_skip_io; op_valid && op_code == skip_io_bit_clear_op
    && !io_bit_value && next_is_two_word
    |=> skip_taken && pc_out == $past(pc_in) + 2'd3; endproperty
  a_skip_io: assert property (p_skip_io)
    else $error("io bit skip pc wrong");
  property p_sb_flags; is_sb |=> !status_we && pc_we; endproperty
  a_sb_flags: assert property (p_sb_flags)
    else $error("skip or branch wrote status");
  property p_br_tgt; branch_taken |-> pc_we && pc_out == tgt_reg; endproperty
  a_br_tgt: assert property (p_br_tgt)
    else $error("branch target wrong");
  property p_seq; pc_we && !skip_taken && !branch_taken
    |-> pc_out == seq_reg; endproperty
  a_seq: assert property (p_seq)
    else $error("sequential pc wrong");
endmodule : csb_exec_sva

bind csb_exec csb_exec_sva #(.PC_W(PC_W), .OFS_W(OFS_W)) i_csb_exec_sva (
  .ref_clk, .rst_n, .op_valid, .op_code, .dest_value, .source_register,
  .imm_value, .bit_sel, .io_bit_value, .pc_in, .branch_offset,
  .next_is_two_word, .status_out, .status_we, .pc_out, .pc_we,
  .skip_taken, .branch_taken);

/* dv/test_compare_skip_branch_exec.sv */
// self-checking bench for the compare, skip and branch execution block
`timescale 1ns/10ps
module test_compare_skip_branch_exec;
  import csb_pkg::*;
  logic       ref_clk = 1'b0, rst_n = 1'b0, op_valid = 1'b0;
  csb_op_e    op_code = no_op;
  logic [7:0] dest_value = 8'h00, source_register = 8'h00, imm_value = 8'h00;
  logic [7:0] status_flags_register = 8'h00, status_out, e_st;
  logic [2:0] bit_sel = 3'h0;
  logic [15:0] pc_in = 16'h0000, pc_out, e_pc;
  logic [6:0] branch_offset = 7'h00;
  logic       io_bit_value = 1'b0, next_is_two_word = 1'b0;
  logic       status_we, pc_we, skip_taken, branch_taken, op_illegal;
  logic       e_swe, e_pcwe, e_skip, e_br, e_ill;
  int         bad_count = 0, num_checks = 0;
  integer     seed = 32'h230ea902;

  always #2.5 ref_clk = ~ref_clk;

  csb_exec i_csb_exec (.ref_clk, .rst_n, .op_valid, .op_code, .dest_value,
    .source_register, .imm_value, .bit_sel, .io_bit_value,
    .status_flags_register, .pc_in, .branch_offset, .next_is_two_word,
    .status_out, .status_we, .pc_out, .pc_we, .skip_taken, .branch_taken,
    .op_illegal);

  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task end_of_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  // ==========================================================================
  // reference model of one clock cycle, idle or illegal included, with status forwarding
  task step();
    logic [7:0] eff, sb, r;
    logic [8:0] w;
    eff = e_swe ? e_st : status_flags_register;
    {e_swe, e_skip, e_br, e_ill} = 4'h0;
    e_pcwe = op_valid;
    e_st = eff;
    sb = (op_code == compare_immediate_op) ? imm_value : source_register;
    w = {1'b0, dest_value} - {1'b0, sb}
      - {8'h00, (op_code == compare_with_carry_op) & eff[FLAG_C]};
    r = w[7:0];
    if (op_valid) case (op_code)
      compare_op, compare_with_carry_op, compare_immediate_op: begin
        e_swe = 1'b1;
        e_st[FLAG_C] = w[8];
        e_st[FLAG_Z] = (r == 8'h00)
          && (op_code != compare_with_carry_op || eff[FLAG_Z]);
        e_st[FLAG_N] = r[7];
        e_st[FLAG_V] = (dest_value[7] & ~sb[7] & ~r[7])
          | (~dest_value[7] & sb[7] & r[7]);
        e_st[FLAG_S] = e_st[FLAG_N] ^ e_st[FLAG_V];
        e_st[FLAG_H] = (~dest_value[3] & sb[3]) | (sb[3] & r[3])
          | (r[3] & ~dest_value[3]);
      end
      skip_reg_bit_clear_op: e_skip = !source_register[bit_sel];
      skip_reg_bit_set_op:   e_skip = source_register[bit_sel];
      skip_io_bit_clear_op:  e_skip = !io_bit_value;
      skip_io_bit_set_op:    e_skip = io_bit_value;
      branch_flag_set_op:    e_br = eff[bit_sel];
      branch_flag_clear_op:  e_br = !eff[bit_sel];
      branch_equal_op:       e_br = eff[FLAG_Z];
      no_op: ;
      default: begin
        e_ill = 1'b1;
        e_pcwe = 1'b0;
      end
    endcase
    if (e_pcwe) e_pc = e_br ? pc_in + {{9{branch_offset[6]}}, branch_offset}
      + 16'h0001 : pc_in + (e_skip ? (next_is_two_word ? 16'h0003 : 16'h0002)
      : 16'h0001);
  endtask : step

  // ==========================================================================
  // every code in turn, then random traffic with idle gaps
  task run(input int n);
    logic [3:0] code;
    logic [7:0] d;
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      code = (i < 16) ? i[3:0] : 4'($random(seed));
      d = 8'($random(seed));
      op_valid <= (i < 16) || ($random(seed) % 4 != 0);
      op_code <= csb_op_e'(code);
      dest_value <= d;
      // equal operands now and then, so compares also see a zero result
      source_register <= (i % 7 == 3) ? d : 8'($random(seed));
      imm_value <= (i % 5 == 0) ? d : 8'($random(seed));
      bit_sel <= 3'($random(seed));
      io_bit_value <= 1'($random(seed));
      status_flags_register <= 8'($random(seed));
      pc_in <= 16'($random(seed));
      branch_offset <= 7'($random(seed));
      next_is_two_word <= 1'($random(seed));
      #1;
      if (i > 0) begin
        chk("status_out", 16'(status_out), 16'(e_st));
        chk("status_we", 16'(status_we), 16'(e_swe));
        chk("pc_we", 16'(pc_we), 16'(e_pcwe));
        chk("pc_out", pc_out, e_pc);
        chk("skip_taken", 16'(skip_taken), 16'(e_skip));
        chk("branch_taken", 16'(branch_taken), 16'(e_br));
        chk("op_illegal", 16'(op_illegal), 16'(e_ill));
      end
      step();
    end
  endtask : run

  initial begin
    {e_st, e_swe, e_pc} = 25'h0000000;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    run(500);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    // nothing stays offered across the reset
    op_valid <= 1'b0;
    #1;
    chk("reset pc_out", pc_out, 16'h0000);
    chk("reset pc_we", 16'(pc_we), 16'h0000);
    chk("reset status_out", {8'h00, status_out}, 16'h0000);
    {e_st, e_swe, e_pc} = 25'h0000000;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    run(200);
    end_of_test();
  end
endmodule : test_compare_skip_branch_exec
